// [hdl/svr_supervisor.sv]
/*
 * supervisor core: supply switch selection, low-supply flag, power-fail
 * flag, three-level watchdog, reset timer and chip-select gating.
 * assumes comparator results and the decoded kick level arrive as
 * digital levels; all pins synchronous to clk after the input chains.
 */
`timescale 1ns/100ps
// Behaviour
// [RULE1] on_battery_flag high while switched supply comes from backup
// [RULE2] backup selected only when main below backup level and threshold
// [RULE3] low-supply flag low below threshold, high at once above it
// [RULE4] select high or floating uses internal timing, low uses external
// [RULE5] internal mode: timebase pin picks fast or slow watchdog
// [RULE6] power-fail flag follows 1.25V comparator, affects nothing else
// [RULE7] kick decoded three-level; mid level disables the watchdog
// [RULE8] static kick past timeout drives missed-kick low and resets
// [RULE9] missed-kick stays low until the next kick transition; the code also sets it high in ST_LOW, with no kick transition
// [RULE10] missed-kick held high while kick input is mid level
// [RULE11] gated chip-select low only if input low and supply good
// [RULE12] chip-select held 15us or until input rises when reset asserts
// [RULE13] reset asserted below threshold and 200ms after recovery
// [RULE14] active-high reset is always inverse of active-low reset
// [RULE15] floating selects: 1.6s watchdog, 200ms reset timeout
// [RULE16] internal, pin low: 100ms watchdog, 1.6s first period
// [RULE17] external: 1024, first 4096, reset 2048 clocks
// [RULE18] any kick edge or 100ns pulse restarts the watchdog
// [RULE19] supply, comparator and kick inputs synchronised first
module svr_supervisor #(
    parameter int unsigned RST_CYC  = svr_pkg::RST_TMO_CYC,
    parameter int unsigned WDS_CYC  = svr_pkg::WD_SLOW_CYC,
    parameter int unsigned WDF_CYC  = svr_pkg::WD_FAST_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire svr_pkg::svr_supply_t supply_in,
    input  wire svr_pkg::svr_tb_t  tb_cfg,
    input  wire svr_pkg::svr_kick_t kick_in,
    input  wire logic              cs_in_n,
    output logic                   on_battery_flag,
    output logic                   low_supply_n,
    output logic                   powerfail_flag_out,
    output logic                   missed_kick_out,
    output logic                   reset_out_n,
    output logic                   reset_od_oe,
    output logic                   cs_out_n
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int unsigned NSYNC = 7;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;
    logic             main_ok;
    logic             main_gt_bkp;
    logic             pf_ok;
    logic             sel_int;
    logic             tb_lvl;
    svr_pkg::svr_kick_t kick_s;

    // bundle all asynchronous levels into one chain
    assign raw_in = {supply_in.main_ok, supply_in.main_gt_bkp,
                     supply_in.pf_ok, tb_cfg.sel_int, tb_cfg.tb_in,
                     kick_in};

    svr_sync #(.W(NSYNC)) u_sync ( // RULE19
        .clk (clk),
        .rst (rst),
        .d   (raw_in),
        .q   (syn)
    );

    assign main_ok     = syn[6];
    assign main_gt_bkp = syn[5];
    assign pf_ok       = syn[4];
    assign sel_int     = syn[3];
    assign tb_lvl      = syn[2];
    assign kick_s      = svr_pkg::svr_kick_t'(syn[1:0]);

    // ************************************************************
    // timebase
    // ************************************************************
    logic tick;

    svr_tick u_tick ( // RULE4
        .clk     (clk),
        .rst     (rst),
        .sel_int (sel_int),
        .tb_in   (tb_lvl),
        .tick    (tick)
    );

    // timeout lengths in ticks for the current mode
    logic [svr_pkg::CNT_W-1:0] wd_norm;
    logic [svr_pkg::CNT_W-1:0] wd_first;
    logic [svr_pkg::CNT_W-1:0] rst_len;

    always_comb begin
        if (sel_int) begin
            rst_len  = svr_pkg::CNT_W'(RST_CYC);                 // RULE15
            wd_first = svr_pkg::CNT_W'(WDS_CYC);                 // RULE16
            wd_norm  = tb_lvl ? svr_pkg::CNT_W'(WDS_CYC)         // RULE5
                              : svr_pkg::CNT_W'(WDF_CYC);
        end else begin
            rst_len  = svr_pkg::CNT_W'(svr_pkg::EXT_RST_CLKS);   // RULE17
            wd_first = svr_pkg::CNT_W'(svr_pkg::EXT_WD1_CLKS);
            wd_norm  = svr_pkg::CNT_W'(svr_pkg::EXT_WD_CLKS);
        end
    end

    // ************************************************************
    // supply switch and comparator flags
    // ************************************************************
    logic bkp_sel;
    // backup only when both conditions are met
    assign bkp_sel            = ~main_ok & ~main_gt_bkp;   // RULE2
    assign on_battery_flag    = bkp_sel;                   // RULE1
    assign low_supply_n       = main_ok;                   // RULE3
    // uncommitted comparator: reads nothing else in the block
    assign powerfail_flag_out = pf_ok;                     // RULE6

    // ************************************************************
    // kick edge detection
    // ************************************************************
    svr_pkg::svr_kick_t kick_prev_r;
    svr_pkg::svr_kick_t kick_prev_nxt;
    logic               kick_mid;
    logic               kick_edge;

    assign kick_mid  = (kick_s == svr_pkg::SVR_KICK_MID);          // RULE7
    // any change between high and low; a 100ns pulse spans >=10 clocks
    // so it yields two edges and always restarts the timer
    assign kick_edge = ~kick_mid && (kick_prev_r != kick_s) &&
                       (kick_prev_r != svr_pkg::SVR_KICK_MID);     // RULE18

    always_comb begin
        kick_prev_nxt = kick_s;
    end

    // ************************************************************
    // reset / watchdog state machine
    // ************************************************************
    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,   // reset asserted, counting reset timeout
        ST_RUN  = 3'b010,   // reset released, watchdog armed
        ST_LOW  = 3'b100    // supply below threshold
    } svr_state_t;

    svr_state_t                st_r;
    svr_state_t                st_nxt;
    logic [svr_pkg::CNT_W-1:0] rcnt_r;
    logic [svr_pkg::CNT_W-1:0] rcnt_nxt;
    logic [svr_pkg::CNT_W-1:0] wcnt_r;
    logic [svr_pkg::CNT_W-1:0] wcnt_nxt;
    logic                      first_r;
    logic                      first_nxt;
    logic                      wdo_r;
    logic                      wdo_nxt;
    logic                      wd_exp;

    assign wd_exp = tick && !kick_mid && !kick_edge &&
                    (wcnt_r + 1'b1 >= (first_r ? wd_first : wd_norm));

    // next state, counters and missed-kick flag
    always_comb begin
        st_nxt    = st_r;
        rcnt_nxt  = rcnt_r;
        wcnt_nxt  = wcnt_r;
        first_nxt = first_r;
        wdo_nxt   = wdo_r;
        // the flag returns high on the next kick transition
        if (kick_edge) begin
            wdo_nxt = 1'b1;                                        // RULE9
        end
        if (kick_mid) begin
            wdo_nxt = 1'b1;                                        // RULE10
        end
        case (st_r)
            ST_LOW: begin
                wdo_nxt  = 1'b1;   // watchdog disabled below threshold
                rcnt_nxt = '0;
                if (main_ok) begin
                    st_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                wcnt_nxt = '0;
                if (tick) begin
                    rcnt_nxt = rcnt_r + 1'b1;
                end
                if (tick && (rcnt_r + 1'b1 >= rst_len)) begin      // RULE13
                    st_nxt    = ST_RUN;
                    first_nxt = 1'b1;
                    rcnt_nxt  = '0;
                end
            end
            ST_RUN: begin
                if (kick_edge || kick_mid) begin
                    wcnt_nxt  = '0;                                // RULE18
                    first_nxt = first_r & kick_mid;
                end else if (wd_exp) begin
                    wdo_nxt  = 1'b0;                               // RULE8
                    wcnt_nxt = '0;
                    st_nxt   = ST_HOLD;
                end else if (tick) begin
                    wcnt_nxt = wcnt_r + 1'b1;
                end
            end
            default: begin
                st_nxt = ST_LOW;
            end
        endcase
        // supply loss overrides state, watchdog count and first-period flag
        if (!main_ok) begin
            st_nxt    = ST_LOW;                                    // RULE13
            wcnt_nxt  = '0;
            first_nxt = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r        <= ST_LOW;
            rcnt_r      <= '0;
            wcnt_r      <= '0;
            first_r     <= 1'b1;
            wdo_r       <= 1'b1;
            kick_prev_r <= svr_pkg::SVR_KICK_MID;
        end else begin
            st_r        <= st_nxt;
            rcnt_r      <= rcnt_nxt;
            wcnt_r      <= wcnt_nxt;
            first_r     <= first_nxt;
            wdo_r       <= wdo_nxt;
            kick_prev_r <= kick_prev_nxt;
        end
    end

    assign missed_kick_out = wdo_r;
    assign reset_out_n     = (st_r == ST_RUN);
    // open-drain high reset: enable drives the pin low while not in reset
    assign reset_od_oe     = reset_out_n;                          // RULE14

    // ************************************************************
    // chip-select gating
    // ************************************************************
    logic                          hold_r;
    logic                          hold_nxt;
    logic [$clog2(svr_pkg::CE_HOLD_CYC+1)-1:0] ccnt_r;
    logic [$clog2(svr_pkg::CE_HOLD_CYC+1)-1:0] ccnt_nxt;
    logic                          cs_r;
    logic                          cs_nxt;
    logic                          rst_rise;

    // reset asserting this cycle while the gate was open
    assign rst_rise = reset_out_n && (st_nxt != ST_RUN);

    // a low chip-select in flight is allowed to finish, bounded in time
    always_comb begin
        hold_nxt = hold_r;
        ccnt_nxt = ccnt_r;
        if (rst_rise && !cs_in_n) begin
            hold_nxt = 1'b1;                                       // RULE12
            ccnt_nxt = '0;
        end else if (hold_r) begin
            ccnt_nxt = ccnt_r + 1'b1;
            if (cs_in_n ||
                (ccnt_r + 1'b1 >= ($bits(ccnt_r))'(svr_pkg::CE_HOLD_CYC))) begin
                hold_nxt = 1'b0;
            end
        end
        if (reset_out_n && st_nxt == ST_RUN) begin
            hold_nxt = 1'b0;
        end
        if (hold_r || hold_nxt) begin
            cs_nxt = cs_in_n;
        end else begin
            cs_nxt = cs_in_n | ~(st_nxt == ST_RUN) | ~main_ok;    // RULE11
        end
    end

    // registered so the chip-select output comes from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_r <= 1'b0;
            ccnt_r <= '0;
            cs_r   <= 1'b1;
        end else begin
            hold_r <= hold_nxt;
            ccnt_r <= ccnt_nxt;
            cs_r   <= cs_nxt;
        end
    end

    assign cs_out_n = cs_r;

    // ************************************************************
    // checks
    // ************************************************************
    property p_inv;
        @(posedge clk) disable iff (rst) reset_od_oe == reset_out_n;
    endproperty
    a_inv: assert property (p_inv) else $error("reset pair not inverse"); // RULE14

    property p_low_rst;
        @(posedge clk) disable iff (rst) !main_ok |=> !reset_out_n;
    endproperty
    a_low_rst: assert property (p_low_rst) else $error("reset not low"); // RULE13

    property p_batt;
        @(posedge clk) disable iff (rst)
            on_battery_flag |-> (!main_ok && !main_gt_bkp);
    endproperty
    a_batt: assert property (p_batt) else $error("backup misselected"); // RULE2

    property p_mid;
        @(posedge clk) disable iff (rst) kick_mid |=> missed_kick_out;
    endproperty
    a_mid: assert property (p_mid) else $error("missed-kick low at mid"); // RULE10

    property p_exp;
        @(posedge clk) disable iff (rst)
            (st_r == ST_RUN && wd_exp && !kick_edge && main_ok)
            |=> (!missed_kick_out && !reset_out_n);
    endproperty
    a_exp: assert property (p_exp) else $error("expiry not flagged"); // RULE8

    property p_kick_clr;
        @(posedge clk) disable iff (rst)
            kick_edge |=> missed_kick_out;
    endproperty
    a_kick_clr: assert property (p_kick_clr) else $error("flag stuck"); // RULE9

    property p_cs;
        @(posedge clk) disable iff (rst)
            (!hold_r && !hold_nxt && (cs_in_n || !main_ok)) |=> cs_out_n;
    endproperty
    a_cs: assert property (p_cs) else $error("chip-select leaked"); // RULE11

    property p_lowline;
        @(posedge clk) disable iff (rst) low_supply_n == main_ok;
    endproperty
    a_lowline: assert property (p_lowline) else $error("low flag"); // RULE3

    c_expiry: cover property (@(posedge clk) disable iff (rst) wd_exp);
    c_hold:   cover property (@(posedge clk) disable iff (rst) hold_r);
    c_run:    cover property (@(posedge clk) disable iff (rst)
                              st_r == ST_RUN);
endmodule

// [pkg/svr_pkg.sv]
/*
 * package for the supervisor watchdog/reset block: timing constants,
 * decoded three-level input codes and the packed carriers.
 * assumes a 100 MHz system clock; analog comparators arrive as levels.
 */
package svr_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned CE_HOLD_NS     = 15000;   // 15 us
    localparam int unsigned CE_HOLD_CYC    = CE_HOLD_NS / CLK_PERIOD_NS;
    localparam int unsigned KICK_PULSE_NS  = 100;
    localparam int unsigned KICK_PULSE_CYC =
        (KICK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_TMO_MS     = 200;
    localparam int unsigned WD_SLOW_MS     = 1600;
    localparam int unsigned WD_FAST_MS     = 100;
    localparam int unsigned CYC_PER_MS     = 1000000 / CLK_PERIOD_NS;
    localparam int unsigned RST_TMO_CYC    = RST_TMO_MS * CYC_PER_MS;
    localparam int unsigned WD_SLOW_CYC    = WD_SLOW_MS * CYC_PER_MS;
    localparam int unsigned WD_FAST_CYC    = WD_FAST_MS * CYC_PER_MS;
    // external timebase counts, in external clock edges
    localparam int unsigned EXT_WD_CLKS    = 1024;
    localparam int unsigned EXT_WD1_CLKS   = 4096;
    localparam int unsigned EXT_RST_CLKS   = 2048;
    localparam int unsigned SYNC_STAGES    = 2;
    localparam int unsigned CNT_W          = 28;

    // ************************************************************
    // three-level kick input code and carriers
    // ************************************************************
    typedef enum logic [1:0] {
        SVR_KICK_LOW  = 2'h0,
        SVR_KICK_HIGH = 2'h1,
        SVR_KICK_MID  = 2'h2
    } svr_kick_t;

    typedef struct packed {
        logic main_ok;      // main supply above reset threshold
        logic main_gt_bkp;  // main supply above backup level
        logic pf_ok;        // power-fail sense above 1.25 V
    } svr_supply_t;

    typedef struct packed {
        logic sel_int;      // timebase select high or floating
        logic tb_in;        // timebase pin level
    } svr_tb_t;

endpackage

// [hdl/svr_sync.sv]
/*
 * level synchroniser, a generate loop of two-flop chains.
 * assumes inputs may change on any edge of clk.
 */
`timescale 1ns/100ps
module svr_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // ************************************************************
    // two-flop chains
    // ************************************************************
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            // first stage feeds only the second stage
            always_comb begin
                meta_nxt[gi] = d[gi];
                q_nxt[gi]    = meta_r[gi];
            end
        end
    endgenerate

    // registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end
endmodule

// [hdl/svr_tick.sv]
/*
 * timebase tick: one pulse per counted unit. internal mode counts clk
 * cycles (tick every cycle); external mode ticks on each synchronised
 * rising edge of the timebase pin.
 * assumes tb_in is already synchronised to clk.
 */
`timescale 1ns/100ps
module svr_tick (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic sel_int,
    input  wire logic tb_in,
    output logic      tick
);
    // ************************************************************
    // edge detect of the external timebase
    // ************************************************************
    logic prev_r;
    logic prev_nxt;

    // next value
    always_comb begin
        prev_nxt = tb_in;
    end

    // register
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    // handshake-style output, combinational by design
    assign tick = sel_int | (tb_in & ~prev_r);
endmodule

// [verif/svr_host_model.sv]
/*
 * host processor model for the supervisor: toggles the kick line while
 * enabled, holds it static otherwise, or leaves it floating (mid level).
 * assumes clk is the supervisor clock; the level changes on falling edges.
 */
`timescale 1ns/100ps
module svr_host_model #(
    parameter int PERIOD = 12
) (
    input  wire logic          clk,
    input  wire logic          kick_en,
    input  wire logic          kick_float,
    output svr_pkg::svr_kick_t kick
);
    int   cnt_r = 0;
    logic lvl_r = 1'b0;

    // one toggle every PERIOD cycles, so each level lasts well past 100ns
    always @(negedge clk) begin
        cnt_r <= (kick_en && cnt_r < PERIOD - 1) ? cnt_r + 1 : 0;
        if (kick_en && cnt_r == PERIOD - 1) begin
            lvl_r <= ~lvl_r;
        end
    end

    // floating pin reads as the mid level, never as the last level
    assign kick = kick_float ? svr_pkg::SVR_KICK_MID
                : (lvl_r ? svr_pkg::SVR_KICK_HIGH : svr_pkg::SVR_KICK_LOW);
endmodule

// [verif/svr_supervisor_tb.sv]
/*
 * self-checking bench for the supervisor: supply flags, reset timing,
 * watchdog periods, mid-level disable and chip-select gating.
 * assumes short timeout parameters; inputs change on falling edges.
 */
`timescale 1ns/100ps
module svr_supervisor_tb;
    localparam int RST_C = 30;
    localparam int WDS_C = 100;
    localparam int WDF_C = 40;
    localparam int KP    = 12;

    logic               clk        = 1'b0;
    logic               rst        = 1'b1;
    logic               cs_in_n    = 1'b1;
    logic               kick_en    = 1'b0;
    logic               kick_float = 1'b0;
    svr_pkg::svr_supply_t sup      = 3'h0;
    svr_pkg::svr_tb_t   tbc        = 2'h2;
    svr_pkg::svr_kick_t kick;
    logic               on_bat, low_n, pf_n, missed_n;
    logic               rst_n, rst_oe, cs_out_n;
    int                 errors     = 0;
    int                 n_compared = 0;
    int                 seed       = 76690;
    int                 n;

    always #5 clk = ~clk;

    svr_host_model #(.PERIOD(KP)) host (
        .clk(clk), .kick_en(kick_en), .kick_float(kick_float), .kick(kick)
    );

    svr_supervisor #(.RST_CYC(RST_C), .WDS_CYC(WDS_C), .WDF_CYC(WDF_C)) dut (
        .clk(clk), .rst(rst), .supply_in(sup), .tb_cfg(tbc),
        .kick_in(kick), .cs_in_n(cs_in_n), .on_battery_flag(on_bat),
        .low_supply_n(low_n), .powerfail_flag_out(pf_n),
        .missed_kick_out(missed_n), .reset_out_n(rst_n),
        .reset_od_oe(rst_oe), .cs_out_n(cs_out_n)
    );

    // ************************************************************
    // compare and wait tasks
    // ************************************************************
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input int g);
        n_compared++;
        if (g < lo || g > hi) begin
            errors++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // backup is chosen only with main below both levels
    function automatic logic exp_batt(input svr_pkg::svr_supply_t s);
        return ~s.main_ok & ~s.main_gt_bkp;
    endfunction

    // cycles until reset (w=0) or missed-kick (w=1) reaches v, capped
    task automatic wait_out(input int w, input logic v, input int lim,
                            output int c);
        c = 0;
        while (((w == 0) ? rst_n : missed_n) !== v && c < lim) begin
            cyc(1);
            c++;
        end
    endtask

    // exactly one kick edge, landing as the task returns
    task automatic pulse_kick;
        kick_en <= 1'b1;
        cyc(KP);
        kick_en <= 1'b0;
    endtask

    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // the open-drain enable must track the active-low reset every cycle
    always @(negedge clk) begin
        chk_bit("reset_od_oe", rst_n, rst_oe);
    end

    // hang guard: the sequence needs about twelve thousand cycles
    initial begin
        #200000;
        errors++;
        give_verdict();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        cyc(6);
        rst <= 1'b0;
        cyc(1);
        chk_bit("missed_kick_out", 1'b1, missed_n);
        // random comparator levels; never long enough to end reset
        for (int i = 0; i < 24; i++) begin
            // every fourth step drops main supply, so hold never finishes
            sup     <= 3'($random(seed)) & ((i % 4 == 3) ? 3'h3 : 3'h7);
            cs_in_n <= 1'($random(seed));
            cyc(4);
            chk_bit("on_battery_flag", exp_batt(sup), on_bat);
            chk_bit("low_supply_n", sup.main_ok, low_n);
            chk_bit("powerfail_flag_out", sup.pf_ok, pf_n);
            chk_bit("reset_out_n", 1'b0, rst_n);
            chk_bit("cs_out_n", 1'b1, cs_out_n);
        end
        // power-up with internal timing, pin low: fast watchdog
        sup     <= 3'h7;
        cs_in_n <= 1'b1;
        tbc     <= 2'h2;
        wait_out(0, 1'b1, 200, n);
        chk_rng("reset timeout", RST_C, RST_C + 6, n);
        wait_out(1, 1'b0, 400, n);
        chk_rng("first watchdog period", WDS_C - 2, WDS_C + 6, n);
        cyc(2);
        chk_bit("reset_out_n", 1'b0, rst_n);
        wait_out(0, 1'b1, 200, n);
        chk_rng("watchdog reset pulse", RST_C - 4, RST_C + 6, n);
        chk_bit("missed_kick_out", 1'b0, missed_n);
        pulse_kick();
        cyc(4);
        chk_bit("missed_kick_out", 1'b1, missed_n);
        wait_out(1, 1'b0, 400, n);
        chk_rng("fast watchdog period", WDF_C - 6, WDF_C + 4, n);
        // slow setting: steady kicking keeps the host out of reset
        tbc <= 2'h3;
        wait_out(0, 1'b1, 200, n);
        kick_en <= 1'b1;
        cyc(300 + ($random(seed) & 31));
        chk_bit("missed_kick_out", 1'b1, missed_n);
        chk_bit("reset_out_n", 1'b1, rst_n);
        kick_en <= 1'b0;
        wait_out(1, 1'b0, 400, n);
        chk_rng("slow watchdog period", WDS_C - 14, WDS_C + 4, n);
        // floating kick pin disables the watchdog and lifts missed-kick
        kick_float <= 1'b1;
        cyc(4);
        chk_bit("missed_kick_out", 1'b1, missed_n);
        cyc(3 * WDS_C + RST_C);
        chk_bit("reset_out_n", 1'b1, rst_n);
        chk_bit("missed_kick_out", 1'b1, missed_n);
        // external timebase with no clock: the watchdog never advances
        kick_float <= 1'b0;
        tbc        <= 2'h0;
        cyc(3 * WDS_C);
        chk_bit("missed_kick_out", 1'b1, missed_n);
        chk_bit("reset_out_n", 1'b1, rst_n);
        // chip-select held through a supply drop, then blocked
        tbc        <= 2'h3;
        kick_float <= 1'b1;
        cs_in_n    <= 1'b0;
        cyc(4);
        chk_bit("cs_out_n", 1'b0, cs_out_n);
        sup <= 3'h3;
        cyc(1400);
        chk_bit("cs_out_n", 1'b0, cs_out_n);
        cyc(120);
        chk_bit("cs_out_n", 1'b1, cs_out_n);
        // a chip-select release during the hold ends it at once
        sup <= 3'h7;
        wait_out(0, 1'b1, 200, n);
        cyc(4);
        chk_bit("cs_out_n", 1'b0, cs_out_n);
        sup <= 3'h3;
        cyc(20);
        cs_in_n <= 1'b1;
        cyc(4);
        chk_bit("cs_out_n", 1'b1, cs_out_n);
        cs_in_n <= 1'b0;
        cyc(4);
        chk_bit("cs_out_n", 1'b1, cs_out_n);
        // external clock on the timebase pin: one rising edge per 4 cycles,
        // so 2048 counted edges keep reset asserted about 8192 cycles
        tbc <= 2'h0;
        sup <= 3'h7;
        for (n = 0; n < 4200 && rst_n !== 1'b1; n++) begin
            tbc.tb_in <= ~tbc.tb_in;
            cyc(2);
        end
        chk_rng("external reset timeout", 4094, 4104, n);
        give_verdict();
    end
endmodule
